// ---- hdl/regspace_pkg.sv ----
// Constants and carrier types for the register-file space decoder
package regspace_pkg;
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 8;
    localparam int          SPACE_BYTES  = 4096;
    localparam int          RAM_MIN      = 2048;
    localparam int          RAM_MAX      = 4096;
    localparam logic [11:0] CTRL_BASE    = 12'h0F00;
    localparam logic [11:0] CTRL_TOP     = 12'h0FFF;
    localparam logic [7:0]  UNMAP_VALUE  = 8'h00;
    localparam logic [7:0]  DATA_RESET   = 8'h00;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b001,
        SEL_RAM  = 3'b010,
        SEL_CTRL = 3'b100
    } target_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } access_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
        target_t           target;
    } reply_t;
endpackage

// ---- hdl/space_select.sv ----
// Combinational address classifier for the register-file space
`timescale 1ns/1ns
`default_nettype none
module space_select
    import regspace_pkg::*;
#(
    parameter int RAM_BYTES = RAM_MIN
) (
    input  wire logic [ADDR_W-1:0] addr,
    output var target_t            target
);
    if (RAM_BYTES < RAM_MIN || RAM_BYTES > RAM_MAX) begin : g_bad_size
        $error("RAM size out of range");
    end

    localparam logic [12:0] RAM_LIMIT = 13'(RAM_BYTES);

    always_comb begin
        if (addr >= CTRL_BASE)
            target = SEL_CTRL;
        else if ({1'b0, addr} < RAM_LIMIT)
            target = SEL_RAM;
        else
            target = SEL_NONE;
    end
endmodule
`default_nettype wire

// ---- hdl/regspace_decoder.sv ----
// Register-file space decoder: RAM, control region and unpopulated gap
`timescale 1ns/1ns
`default_nettype none
module regspace_decoder
    import regspace_pkg::*;
#(
    parameter int RAM_BYTES = RAM_MIN
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire access_t             req,
    input  wire logic [DATA_W-1:0]   ctrl_rdata,
    output var reply_t               reply,
    output logic                     ctrl_sel,
    output logic                     ctrl_we,
    output logic [7:0]               ctrl_addr,
    output logic [DATA_W-1:0]        ctrl_wdata
);
    typedef struct packed {
        reply_t            reply;
        logic              ctrl_sel;
        logic              ctrl_we;
        logic [7:0]        ctrl_addr;
        logic [DATA_W-1:0] ctrl_wdata;
        logic              ctrl_pend;
    } state_t;

    // RAM contents are left alone in reset; only the handshake state returns to idle
    localparam state_t STATE_IDLE = '{
        reply:      '{valid: 1'b0, rdata: DATA_RESET, target: SEL_NONE},
        ctrl_sel:   1'b0,
        ctrl_we:    1'b0,
        ctrl_addr:  8'h00,
        ctrl_wdata: DATA_RESET,
        ctrl_pend:  1'b0
    };

    state_t state_reg;
    state_t state_next;
    target_t sel;
    logic [DATA_W-1:0] ram [RAM_BYTES];
    logic [DATA_W-1:0] ram_q;
    logic              ram_rd;

    if (RAM_BYTES < RAM_MIN || RAM_BYTES > RAM_MAX) begin : g_bad_size
        $error("RAM size out of range");
    end

    // A size that is not a power of two still needs the full index; the classifier keeps it in range
    localparam int RAM_IDX_W = $clog2(RAM_BYTES);

    // Address-only region test for the checks, kept apart from the classifier it guards
    function automatic target_t region_of(input logic [ADDR_W-1:0] a);
        if (a >= CTRL_BASE)
            return SEL_CTRL;
        else if ({1'b0, a} < (ADDR_W+1)'(RAM_BYTES))
            return SEL_RAM;
        else
            return SEL_NONE;
    endfunction

    space_select #(.RAM_BYTES(RAM_BYTES)) u_sel (
        .addr   (req.addr),
        .target (sel)
    );

    // RAM is kept in its own process so it can map onto a block memory
    always_ff @(posedge clock) begin
        ram_rd <= 1'b0;
        // Held off in reset so a stray request cannot leave a read answer pending at release
        if (!rst && req.valid && sel == SEL_RAM) begin
            if (req.write)
                ram[req.addr[RAM_IDX_W-1:0]] <= req.wdata;
            else
                ram_rd <= 1'b1;
            ram_q <= ram[req.addr[RAM_IDX_W-1:0]];
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.reply.valid = 1'b0;
        state_next.ctrl_sel = 1'b0;
        state_next.ctrl_we = 1'b0;
        state_next.ctrl_pend = 1'b0;
        if (req.valid) begin
            state_next.reply.target = sel;
            case (sel)
                SEL_CTRL: begin
                    // Reserved offsets reach the peripherals unfiltered; they answer as they like
                    state_next.ctrl_sel = 1'b1;
                    state_next.ctrl_we = req.write;
                    state_next.ctrl_addr = req.addr[7:0];
                    state_next.ctrl_wdata = req.wdata;
                    state_next.ctrl_pend = ~req.write;
                end
                SEL_RAM: begin
                    state_next.reply.valid = req.write;      // reads answer a cycle later
                end
                default: begin
                    state_next.reply.valid = 1'b1;
                    state_next.reply.rdata = UNMAP_VALUE;
                end
            endcase
        end
        if (ram_rd) begin
            state_next.reply.valid = 1'b1;
            state_next.reply.rdata = ram_q;
        end
        if (state_reg.ctrl_pend) begin
            state_next.reply.valid = 1'b1;
            state_next.reply.rdata = ctrl_rdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= STATE_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reply = state_reg.reply;
    assign ctrl_sel = state_reg.ctrl_sel;
    assign ctrl_we = state_reg.ctrl_we;
    assign ctrl_addr = state_reg.ctrl_addr;
    assign ctrl_wdata = state_reg.ctrl_wdata;

    // The checks decode the address on their own, so a slip in the classifier shows up here
    a_onehot_target: assert property (@(posedge clock) disable iff (rst)
        req.valid |=> $onehot(reply.target))
        else $error("target not one-hot");
    a_ctrl_region: assert property (@(posedge clock) disable iff (rst)
        req.valid && region_of(req.addr) == SEL_CTRL |=> ctrl_sel && reply.target == SEL_CTRL)
        else $error("control address not steered to control");
    a_ram_region: assert property (@(posedge clock) disable iff (rst)
        req.valid && region_of(req.addr) == SEL_RAM |=> !ctrl_sel && reply.target == SEL_RAM)
        else $error("RAM address not steered to RAM");
    a_gap_quiet: assert property (@(posedge clock) disable iff (rst)
        req.valid && region_of(req.addr) == SEL_NONE |=> !ctrl_sel && reply.valid && reply.target == SEL_NONE)
        else $error("gap access not answered quietly");
    a_gap_read_zero: assert property (@(posedge clock) disable iff (rst)
        req.valid && !req.write && region_of(req.addr) == SEL_NONE |=> reply.rdata == UNMAP_VALUE)
        else $error("gap read value wrong");
    a_ctrl_read_ans: assert property (@(posedge clock) disable iff (rst)
        req.valid && !req.write && region_of(req.addr) == SEL_CTRL |=> ##1 reply.valid)
        else $error("control read unanswered");
    a_ctrl_rdata_pass: assert property (@(posedge clock) disable iff (rst)
        req.valid && !req.write && region_of(req.addr) == SEL_CTRL |=> ##1 reply.rdata == $past(ctrl_rdata))
        else $error("control read data not passed on");
    a_ram_roundtrip: assert property (@(posedge clock) disable iff (rst)
        req.valid && !req.write && region_of(req.addr) == SEL_RAM |=> ##1 reply.valid && reply.target == SEL_RAM)
        else $error("RAM read unanswered");
    a_ram_write_ans: assert property (@(posedge clock) disable iff (rst)
        req.valid && req.write && region_of(req.addr) == SEL_RAM |=> reply.valid && !ctrl_sel)
        else $error("RAM write unanswered");
    a_ctrl_write: assert property (@(posedge clock) disable iff (rst)
        req.valid && req.write && region_of(req.addr) == SEL_CTRL |=> ctrl_we && ctrl_wdata == $past(req.wdata))
        else $error("control write lost");
    a_ctrl_addr: assert property (@(posedge clock) disable iff (rst)
        req.valid && region_of(req.addr) == SEL_CTRL |=> ctrl_addr == $past(req.addr[7:0]))
        else $error("control offset wrong");
    a_we_with_sel: assert property (@(posedge clock) disable iff (rst)
        ctrl_we |-> ctrl_sel)
        else $error("control write strobe without select");
    a_idle_quiet: assert property (@(posedge clock) disable iff (rst)
        !req.valid |=> !ctrl_sel)
        else $error("control select without request");
    a_target_holds: assert property (@(posedge clock) disable iff (rst)
        !req.valid |=> $stable(reply.target))
        else $error("target changed without request");
    a_offset_holds: assert property (@(posedge clock) disable iff (rst)
        !req.valid |=> $stable(ctrl_addr) && $stable(ctrl_wdata))
        else $error("control offset or data changed without request");
    a_reset_quiet: assert property (@(posedge clock)
        rst |=> !reply.valid && !ctrl_sel && !ctrl_we && reply.target == SEL_NONE)
        else $error("outputs not idle after reset");

    c_ram_read:   cover property (@(posedge clock) req.valid && !req.write && sel == SEL_RAM);
    c_ram_write:  cover property (@(posedge clock) req.valid && req.write && sel == SEL_RAM);
    c_ctrl_read:  cover property (@(posedge clock) req.valid && !req.write && sel == SEL_CTRL);
    c_ctrl_write: cover property (@(posedge clock) req.valid && req.write && sel == SEL_CTRL);
    c_gap_write:  cover property (@(posedge clock) req.valid && req.write && sel == SEL_NONE);
endmodule
`default_nettype wire

// ---- dv/ctrl_bank_model.sv ----
// Behavioural model of the control registers behind the decoder
`timescale 1ns/1ns
`default_nettype none
module ctrl_bank_model (
    input  wire logic       clock,
    input  wire logic       ctrl_sel,
    input  wire logic       ctrl_we,
    input  wire logic [7:0] ctrl_addr,
    input  wire logic [7:0] ctrl_wdata,
    output logic      [7:0] ctrl_rdata
);
    // Unwritten offsets read as unknown, as a reserved register may
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    always_ff @(posedge clock) begin
        if (ctrl_sel && ctrl_we) mem[ctrl_addr] <= ctrl_wdata;
        if (ctrl_sel) last <= mem[ctrl_addr];
    end
    // Bus not selected shows the inverse of the last value, never a stale match
    assign ctrl_rdata = ctrl_sel ? mem[ctrl_addr] : ~last;
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the register-file space decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import regspace_pkg::*;
;
    localparam int RAM_BYTES = 3072;
    logic       clock       = 1'b0;
    logic       rst         = 1'b1;
    access_t    req         = '0;
    reply_t     reply;
    logic       ctrl_sel, ctrl_we, s_sel, s_we;
    logic [7:0] ctrl_addr, ctrl_wdata, ctrl_rdata, got, s_addr;
    target_t    tgt;
    int         errors      = 0;
    int         check_count = 0;
    initial forever #25 clock = ~clock;
    regspace_decoder #(.RAM_BYTES(RAM_BYTES)) dut_u (.clock(clock), .rst(rst), .req(req),
        .ctrl_rdata(ctrl_rdata), .reply(reply), .ctrl_sel(ctrl_sel), .ctrl_we(ctrl_we),
        .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata));
    ctrl_bank_model bank_u (.clock(clock), .ctrl_sel(ctrl_sel), .ctrl_we(ctrl_we),
        .ctrl_addr(ctrl_addr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata));
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // One access, held valid for the taking edge only; waits boundedly for the reply
    task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge clock);
        req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
        @(posedge clock);
        req.valid <= 1'b0;
        s_sel = 1'b0;
        for (i = 0; i < 4; i++) begin
            #1;
            if (ctrl_sel === 1'b1) {s_sel, s_we, s_addr} = {1'b1, ctrl_we, ctrl_addr};
            // Control writes raise no reply; the write strobe is their answer
            if (reply.valid === 1'b1 || (ctrl_sel === 1'b1 && ctrl_we === 1'b1)) break;
            @(posedge clock);
        end
        if (i == 4) begin
            errors++;
            $display("MISMATCH at %0t: no answer to access", $time);
            give_verdict();
        end
        got = reply.rdata;
        tgt = reply.target;
    endtask
    task automatic t_reset();
        chk({7'h0, reply.valid}, 8'h00);
        chk({5'h0, reply.target}, {5'h0, SEL_NONE});
        chk({7'h0, ctrl_sel}, 8'h00);
    endtask
    // Both ends of the default 2 KB and of the configured size
    task automatic t_ram();
        logic [11:0] al [4] = '{12'h000, 12'h7FF, 12'h800, 12'hBFF};
        foreach (al[k]) access(1'b1, al[k], {al[k][11:8], al[k][3:0]});
        foreach (al[k]) begin
            access(1'b0, al[k], 8'h00);
            chk(got, {al[k][11:8], al[k][3:0]});
            chk({5'h0, tgt}, {5'h0, SEL_RAM});
            chk({7'h0, s_sel}, 8'h00);
        end
    endtask
    // Gap writes must not alias onto RAM through dropped address bits
    task automatic t_gap();
        access(1'b1, 12'hC00, 8'hFF);
        chk({5'h0, tgt}, {5'h0, SEL_NONE});
        chk({7'h0, s_sel}, 8'h00);
        access(1'b0, 12'h400, 8'h00);
        chk(got, 8'h3C);
        access(1'b0, 12'hEFF, 8'h00);
        chk(got, UNMAP_VALUE);
        chk({5'h0, tgt}, {5'h0, SEL_NONE});
    endtask
    // Only offsets written here are read back, so no reserved place is read
    task automatic t_ctrl();
        logic [11:0] al [2] = '{12'hF00, 12'hFFF};
        foreach (al[k]) begin
            access(1'b1, al[k], {4'hA, al[k][3:0]});
            chk({s_sel, s_we, 6'h0}, 8'hC0);
            chk(s_addr, al[k][7:0]);
            chk({5'h0, tgt}, {5'h0, SEL_CTRL});
            access(1'b0, al[k], 8'h00);
            chk(got, {4'hA, al[k][3:0]});
            chk({s_sel, s_we, 6'h0}, 8'h80);
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        #1;
        t_reset();
        access(1'b1, 12'h400, 8'h3C);
        t_ram();
        t_gap();
        t_ctrl();
        give_verdict();
    end
endmodule
`default_nettype wire
